// ==== rtl/asmlo_alu.sv ====
`timescale 1ns/100ps
// Summary of operation
// - Word minus: destination less source, written back
// - Word post-increment pointer fetch, then step two
// - Byte post-increment pointer fetch, then step one
// - Word borrow variant subtracts carry too
// - Short form uses three-bit opcode constant
// - Long word form uses sixteen-bit constant
// - Memory destination: read, combine, write back; invert and two's complement skip the read
// - Long byte form uses eight-bit constant
// - Byte borrow variant subtracts carry too
// - Signed product of two word registers
// - Unsigned product of two word registers
// - Signed short quotient of low half
// - Signed long quotient of full register
// - Unsigned long quotient of full register
// - Unsigned short quotient of low half
// - Invert every bit of register in place
// - Replace register with its two's complement
// - Bitwise AND into destination
// - Bitwise OR into destination
// - Bitwise XOR into destination
// - Long immediate or direct forms are four bytes
// - Byte logic post-increment steps pointer one
module asmlo_alu
	import asmlo_pkg::*;
(
	input  wire logic               CLOCK,
	input  wire logic               RESET_N,
	input  wire logic               CMD_VALID,
	output logic                    CMD_READY,
	input  wire asmlo_cmd_type      CMD,
	input  wire asmlo_load_type     LOAD,
	output logic                    MEM_REQ,
	output asmlo_mem_type           MEM_OUT,
	input  wire logic               MEM_ACK,
	input  wire logic [WORD_W-1:0]  MEM_RDATA,
	output logic                    DONE,
	output logic      [LEN_W-1:0]   INSN_LEN,
	output asmlo_flags_type         FLAGS,
	output logic      [PQ_W-1:0]    PQ_REG,
	input  wire logic [GPR_IDX_W-1:0] GPR_SEL,
	output logic      [WORD_W-1:0]  GPR_DATA
);

	asmlo_state_type   state_ff, nxt_state;
	asmlo_cmd_type     cmd_ff, nxt_cmd;
	asmlo_mem_type     mem_ff, nxt_mem;
	asmlo_flags_type   flags_ff, nxt_flags;
	logic [WORD_W-1:0] gpr_ff [GPR_N];
	logic [WORD_W-1:0] nxt_gpr [GPR_N];
	logic [WORD_W-1:0] mdata_ff, nxt_mdata;
	logic [PQ_W-1:0]   pq_ff, nxt_pq;
	logic              done_ff, nxt_done;
	logic [LEN_W-1:0]  len_ff, nxt_len;
	logic [WORD_W-1:0] rd_ff, nxt_rd;

	logic [WORD_W-1:0] op_a, op_b, res, res_m, dst_word, src_word;
	logic [WORD_W:0]   diff;
	logic              cin, arith, logic_op, is_prod, is_quot;
	logic [PQ_W-1:0]   sprod, uprod, q_dividend;
	logic              q_start, q_signed, q_done;
	logic [WORD_W-1:0] q_quot, q_rem;

	// ==========================================================
	// Register file access helpers
	function automatic logic [WORD_W-1:0] rd_reg(
		input logic [WORD_W-1:0]    regs [GPR_N],
		input logic [GPR_IDX_W-1:0] idx,
		input logic                 bsel
	);
		logic [WORD_W-1:0] w;
		w = regs[{1'b0, idx[GPR_IDX_W-1:1]}];
		if (bsel)
			rd_reg = {BYTE_ZERO, idx[0] ? w[WORD_W-1:BYTE_W] : w[BYTE_W-1:0]};
		else
			rd_reg = regs[idx];
	endfunction : rd_reg

	function automatic logic sign_of(
		input logic [WORD_W-1:0] v,
		input logic              bsel
	);
		sign_of = bsel ? v[BYTE_SIGN] : v[WORD_SIGN];
	endfunction : sign_of

	function automatic logic [LEN_W-1:0] len_of(input asmlo_form_type f);
		case (f)
			FORM_IMM_LONG, FORM_REG_MEM, FORM_MEM_REG: len_of = LEN_LONG;
			default: len_of = LEN_SHORT;
		endcase
	endfunction : len_of

	// ==========================================================
	// Operand selection
	assign dst_word = gpr_ff[cmd_ff.dst];
	assign src_word = gpr_ff[cmd_ff.src];

	always_comb begin
		case (cmd_ff.form)
			FORM_IND, FORM_IND_INC, FORM_REG_MEM: op_b = mdata_ff;
			FORM_IMM3: op_b = {{(WORD_W-IMM3_W){1'b0}},
				cmd_ff.imm[IMM3_W-1:0]};
			FORM_IMM_LONG: op_b = cmd_ff.byte_op ?
				{BYTE_ZERO, cmd_ff.imm[BYTE_W-1:0]} :
				cmd_ff.imm;
			default: op_b = rd_reg(gpr_ff, cmd_ff.src, cmd_ff.byte_op);
		endcase
		if (cmd_ff.form == FORM_MEM_REG)
			op_a = mdata_ff;
		else
			op_a = rd_reg(gpr_ff, cmd_ff.dst, cmd_ff.byte_op);
	end

	// ==========================================================
	// Arithmetic and logic
	assign is_prod = cmd_ff.op inside {OP_SIGNED_PRODUCT, OP_UNSIGNED_PRODUCT};
	assign is_quot = cmd_ff.op inside {OP_SIGNED_QUOTIENT_SHORT,
		OP_SIGNED_QUOTIENT_LONG, OP_UNSIGNED_QUOTIENT_LONG,
		OP_UNSIGNED_QUOTIENT_SHORT};
	assign arith = cmd_ff.op inside {OP_MINUS, OP_MINUS_BORROW,
		OP_TWOS_COMPLEMENT};
	assign logic_op = !arith && !is_prod && !is_quot;
	assign cin = (cmd_ff.op == OP_MINUS_BORROW) & flags_ff.c;

	always_comb begin
		if (cmd_ff.op == OP_TWOS_COMPLEMENT)
			diff = {1'b0, WORD_ZERO} - {1'b0, op_a};
		else
			diff = {1'b0, op_a} - {1'b0, op_b} - {{WORD_W{1'b0}}, cin};
		case (cmd_ff.op)
			OP_INVERT:            res = ~op_a;
			OP_BITWISE_CONJ:      res = op_a & op_b;
			OP_BITWISE_DISJ:      res = op_a | op_b;
			OP_BITWISE_EXCLUSIVE: res = op_a ^ op_b;
			default:              res = diff[WORD_W-1:0];
		endcase
		res_m = cmd_ff.byte_op ? {BYTE_ZERO, res[BYTE_W-1:0]} : res;
	end

	assign sprod = PQ_W'($signed(dst_word) * $signed(src_word));
	assign uprod = PQ_W'(dst_word * src_word);

	// ==========================================================
	// Quotient unit feed
	assign q_start  = (state_ff == ST_EXEC) && is_quot && (dst_word != WORD_ZERO);
	assign q_signed = cmd_ff.op inside {OP_SIGNED_QUOTIENT_SHORT,
		OP_SIGNED_QUOTIENT_LONG};

	always_comb begin
		case (cmd_ff.op)
			OP_SIGNED_QUOTIENT_SHORT:
				q_dividend = {{WORD_W{pq_ff[WORD_SIGN]}}, pq_ff[WORD_W-1:0]};
			OP_UNSIGNED_QUOTIENT_SHORT:
				q_dividend = {WORD_ZERO, pq_ff[WORD_W-1:0]};
			default: q_dividend = pq_ff;
		endcase
	end

	asmlo_quotient_unit #(
		.DW (PQ_W),
		.VW (WORD_W)
	) u_quot (
		.clk       (CLOCK),
		.rst_n     (RESET_N),
		.start     (q_start),
		.is_signed (q_signed),
		.dividend  (q_dividend),
		.divisor   (dst_word),
		.done      (q_done),
		.quotient  (q_quot),
		.remainder (q_rem)
	);

	// ==========================================================
	// Sequencer and state update
	always_comb begin
		nxt_state = state_ff;
		nxt_cmd   = cmd_ff;
		nxt_mem   = mem_ff;
		nxt_flags = flags_ff;
		nxt_gpr   = gpr_ff;
		nxt_mdata = mdata_ff;
		nxt_pq    = pq_ff;
		nxt_done  = 1'b0;
		nxt_len   = len_ff;
		nxt_rd    = gpr_ff[GPR_SEL];
		case (state_ff)
			ST_IDLE: begin
				if (LOAD.gpr_en)
					nxt_gpr[LOAD.sel] = LOAD.data;
				if (LOAD.pq_en)
					nxt_pq = LOAD.pq;
				if (LOAD.flags_en)
					nxt_flags = LOAD.flags;
				if (CMD_VALID) begin
					nxt_cmd     = CMD;
					nxt_mem.we  = 1'b0;
					nxt_mem.byte_sel = CMD.byte_op;
					nxt_mem.addr = (CMD.form inside {FORM_IND, FORM_IND_INC}) ?
						gpr_ff[CMD.src] : CMD.addr;
					if (CMD.form inside {FORM_IND, FORM_IND_INC, FORM_REG_MEM,
						FORM_MEM_REG} && CMD.op inside {OP_MINUS,
						OP_MINUS_BORROW, OP_BITWISE_CONJ, OP_BITWISE_DISJ,
						OP_BITWISE_EXCLUSIVE})
						nxt_state = ST_FETCH;
					else
						nxt_state = ST_EXEC;
				end
			end
			ST_FETCH: begin
				if (MEM_ACK) begin
					nxt_mdata = cmd_ff.byte_op ?
						{BYTE_ZERO, MEM_RDATA[BYTE_W-1:0]} : MEM_RDATA;
					if (cmd_ff.form == FORM_IND_INC)
						nxt_gpr[cmd_ff.src] = gpr_ff[cmd_ff.src] +
							(cmd_ff.byte_op ? PTR_STEP_BYTE :
							PTR_STEP_WORD);
					nxt_state = ST_EXEC;
				end
			end
			ST_EXEC: begin
				nxt_state = ST_IDLE;
				nxt_done  = 1'b1;
				nxt_len   = len_of(cmd_ff.form);
				if (is_prod) begin
					nxt_pq = (cmd_ff.op == OP_SIGNED_PRODUCT) ?
						sprod : uprod;
					nxt_flags.c = 1'b0;
					nxt_flags.v = 1'b0;
					nxt_flags.z = (nxt_pq == PQ_RESET);
					nxt_flags.n = nxt_pq[PQ_W-1];
				end else if (is_quot) begin
					if (dst_word == WORD_ZERO) begin
						nxt_flags.v = 1'b1;
						nxt_flags.c = 1'b0;
					end else begin
						nxt_state = ST_QUOT;
						nxt_done  = 1'b0;
					end
				end else begin
					nxt_flags.z = (res_m == WORD_ZERO);
					nxt_flags.n = sign_of(res_m, cmd_ff.byte_op);
					if (arith) begin
						nxt_flags.c = cmd_ff.byte_op ? diff[BYTE_W] : diff[WORD_W];
						nxt_flags.v = (cmd_ff.op == OP_TWOS_COMPLEMENT) ?
							(sign_of(op_a, cmd_ff.byte_op) &
							sign_of(res_m, cmd_ff.byte_op)) :
							((sign_of(op_a, cmd_ff.byte_op) ^
							sign_of(op_b, cmd_ff.byte_op)) &
							(sign_of(op_a, cmd_ff.byte_op) ^
							sign_of(res_m, cmd_ff.byte_op)));
					end else if (logic_op) begin
						nxt_flags.c = 1'b0;
						nxt_flags.v = 1'b0;
					end
					if (cmd_ff.form == FORM_MEM_REG) begin
						nxt_mem.we    = 1'b1;
						nxt_mem.wdata = res_m;
						nxt_state     = ST_STORE;
						nxt_done      = 1'b0;
					end else if (cmd_ff.byte_op) begin
						if (cmd_ff.dst[0])
							nxt_gpr[{1'b0, cmd_ff.dst[GPR_IDX_W-1:1]}][WORD_W-1:BYTE_W] =
								res_m[BYTE_W-1:0];
						else
							nxt_gpr[{1'b0, cmd_ff.dst[GPR_IDX_W-1:1]}][BYTE_W-1:0] =
								res_m[BYTE_W-1:0];
					end else begin
						nxt_gpr[cmd_ff.dst] = res_m;
					end
				end
			end
			ST_QUOT: begin
				if (q_done) begin
					nxt_pq    = {q_rem, q_quot};
					nxt_flags = {1'b0, 1'b0, q_quot == WORD_ZERO, q_quot[WORD_SIGN]};
					nxt_state = ST_IDLE;
					nxt_done  = 1'b1;
				end
			end
			ST_STORE: begin
				if (MEM_ACK) begin
					nxt_mem.we = 1'b0;
					nxt_state  = ST_IDLE;
					nxt_done   = 1'b1;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_ff <= ST_IDLE;
			cmd_ff   <= '0;
			mem_ff   <= '0;
			flags_ff <= FLAGS_RESET;
			gpr_ff   <= '{default: GPR_RESET};
			mdata_ff <= WORD_ZERO;
			pq_ff    <= PQ_RESET;
			done_ff  <= 1'b0;
			len_ff   <= LEN_SHORT;
			rd_ff    <= WORD_ZERO;
		end else begin
			state_ff <= nxt_state;
			cmd_ff   <= nxt_cmd;
			mem_ff   <= nxt_mem;
			flags_ff <= nxt_flags;
			gpr_ff   <= nxt_gpr;
			mdata_ff <= nxt_mdata;
			pq_ff    <= nxt_pq;
			done_ff  <= nxt_done;
			len_ff   <= nxt_len;
			rd_ff    <= nxt_rd;
		end
	end

	assign CMD_READY = (state_ff == ST_IDLE);
	assign MEM_REQ   = (state_ff == ST_FETCH) || (state_ff == ST_STORE);
	assign MEM_OUT   = mem_ff;
	assign DONE      = done_ff;
	assign INSN_LEN  = len_ff;
	assign FLAGS     = flags_ff;
	assign PQ_REG    = pq_ff;
	assign GPR_DATA  = rd_ff;

	// ==========================================================
	// Checks
	len_code_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		DONE |-> INSN_LEN == len_of(cmd_ff.form))
		else $error("instruction length mismatch");

	ptr_word_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		(state_ff == ST_FETCH && MEM_ACK && cmd_ff.form == FORM_IND_INC &&
		!cmd_ff.byte_op) |=> gpr_ff[$past(cmd_ff.src)] ==
		$past(src_word) + PTR_STEP_WORD)
		else $error("word pointer not advanced by two");

	ptr_byte_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		(state_ff == ST_FETCH && MEM_ACK && cmd_ff.form == FORM_IND_INC &&
		cmd_ff.byte_op) |=> gpr_ff[$past(cmd_ff.src)] ==
		$past(src_word) + PTR_STEP_BYTE)
		else $error("byte pointer not advanced by one");

	minus_word_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		(state_ff == ST_EXEC && cmd_ff.op == OP_MINUS && !cmd_ff.byte_op &&
		cmd_ff.form == FORM_REG_REG) |=> (gpr_ff[$past(cmd_ff.dst)] ==
		WORD_W'($past(op_a) - $past(op_b))) && DONE)
		else $error("word difference wrong");

	borrow_word_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		(state_ff == ST_EXEC && cmd_ff.op == OP_MINUS_BORROW &&
		!cmd_ff.byte_op && cmd_ff.form != FORM_MEM_REG) |=>
		gpr_ff[$past(cmd_ff.dst)] == WORD_W'($past(op_a) - $past(op_b) -
		{{(WORD_W-1){1'b0}}, $past(flags_ff.c)}))
		else $error("carry not taken into difference");

	product_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		(state_ff == ST_EXEC && cmd_ff.op == OP_SIGNED_PRODUCT) |=>
		($signed(PQ_REG) == $signed($past(dst_word)) *
		$signed($past(src_word))) && DONE)
		else $error("signed product wrong");

	invert_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		(state_ff == ST_EXEC && cmd_ff.op == OP_INVERT && !cmd_ff.byte_op)
		|=> gpr_ff[$past(cmd_ff.dst)] == ~$past(dst_word))
		else $error("complement wrong");

	xor_word_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		(state_ff == ST_EXEC && cmd_ff.op == OP_BITWISE_EXCLUSIVE &&
		!cmd_ff.byte_op && cmd_ff.form != FORM_MEM_REG) |=>
		gpr_ff[$past(cmd_ff.dst)] == ($past(op_a) ^ $past(op_b)) &&
		!FLAGS.c && !FLAGS.v)
		else $error("exclusive or wrong");

	store_back_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		(state_ff == ST_EXEC && !is_quot && !is_prod &&
		cmd_ff.form == FORM_MEM_REG) |=> MEM_REQ && MEM_OUT.we &&
		MEM_OUT.wdata == $past(res_m))
		else $error("memory result not written back");

endmodule : asmlo_alu

// ==== include/asmlo_pkg.sv ====
package asmlo_pkg;

	// ==========================================================
	// Widths and counts
	localparam int WORD_W    = 16;
	localparam int BYTE_W    = 8;
	localparam int GPR_N     = 16;
	localparam int GPR_IDX_W = 4;
	localparam int PQ_W      = 32;
	localparam int LEN_W     = 3;
	localparam int IMM3_W    = 3;
	localparam int WORD_SIGN = 15;
	localparam int BYTE_SIGN = 7;

	// ==========================================================
	// Encoded lengths, pointer steps, reset values
	localparam logic [LEN_W-1:0]  LEN_SHORT     = 3'h2;
	localparam logic [LEN_W-1:0]  LEN_LONG      = 3'h4;
	localparam logic [WORD_W-1:0] PTR_STEP_WORD = 16'h0002;
	localparam logic [WORD_W-1:0] PTR_STEP_BYTE = 16'h0001;
	localparam logic [WORD_W-1:0] GPR_RESET     = 16'h0000;
	localparam logic [WORD_W-1:0] WORD_ZERO     = 16'h0000;
	localparam logic [BYTE_W-1:0] BYTE_ZERO     = 8'h00;
	localparam logic [PQ_W-1:0]   PQ_RESET      = 32'h0000_0000;

	// ==========================================================
	// Operations and addressing forms
	typedef enum logic [3:0] {
		OP_MINUS,
		OP_MINUS_BORROW,
		OP_SIGNED_PRODUCT,
		OP_UNSIGNED_PRODUCT,
		OP_SIGNED_QUOTIENT_SHORT,
		OP_SIGNED_QUOTIENT_LONG,
		OP_UNSIGNED_QUOTIENT_LONG,
		OP_UNSIGNED_QUOTIENT_SHORT,
		OP_INVERT,
		OP_TWOS_COMPLEMENT,
		OP_BITWISE_CONJ,
		OP_BITWISE_DISJ,
		OP_BITWISE_EXCLUSIVE
	} asmlo_op_type;

	typedef enum logic [2:0] {
		FORM_REG_REG,
		FORM_IND,
		FORM_IND_INC,
		FORM_IMM3,
		FORM_IMM_LONG,
		FORM_REG_MEM,
		FORM_MEM_REG
	} asmlo_form_type;

	typedef enum {
		ST_IDLE,
		ST_FETCH,
		ST_EXEC,
		ST_QUOT,
		ST_STORE
	} asmlo_state_type;

	// ==========================================================
	// Carriers
	typedef struct packed {
		asmlo_op_type          op;
		asmlo_form_type        form;
		logic                  byte_op;
		logic [GPR_IDX_W-1:0]  dst;
		logic [GPR_IDX_W-1:0]  src;
		logic [WORD_W-1:0]     imm;
		logic [WORD_W-1:0]     addr;
	} asmlo_cmd_type;

	typedef struct packed {
		logic c;
		logic v;
		logic z;
		logic n;
	} asmlo_flags_type;

	localparam asmlo_flags_type FLAGS_RESET = 4'h0;

	typedef struct packed {
		logic              we;
		logic              byte_sel;
		logic [WORD_W-1:0] addr;
		logic [WORD_W-1:0] wdata;
	} asmlo_mem_type;

	typedef struct packed {
		logic                 gpr_en;
		logic [GPR_IDX_W-1:0] sel;
		logic [WORD_W-1:0]    data;
		logic                 pq_en;
		logic [PQ_W-1:0]      pq;
		logic                 flags_en;
		asmlo_flags_type      flags;
	} asmlo_load_type;

endpackage : asmlo_pkg

// ==== rtl/asmlo_quotient_unit.sv ====
`timescale 1ns/100ps
module asmlo_quotient_unit
	import asmlo_pkg::*;
#(
	parameter int DW = PQ_W,
	parameter int VW = WORD_W
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          start,
	input  wire logic          is_signed,
	input  wire logic [DW-1:0] dividend,
	input  wire logic [VW-1:0] divisor,
	output logic               done,
	output logic      [VW-1:0] quotient,
	output logic      [VW-1:0] remainder
);

	localparam int CW = $clog2(DW + 1);

	logic          busy_ff, nxt_busy;
	logic [CW-1:0] cnt_ff, nxt_cnt;
	logic [VW:0]   rem_ff, nxt_rem;
	logic [DW-1:0] quo_ff, nxt_quo;
	logic [VW-1:0] dvs_ff, nxt_dvs;
	logic          neg_q_ff, nxt_neg_q, neg_r_ff, nxt_neg_r;
	logic          done_ff, nxt_done;
	logic [VW-1:0] q_ff, nxt_q, r_ff, nxt_r;

	// ==========================================================
	// Restoring shift-subtract on magnitudes, one bit a cycle
	always_comb begin
		logic [VW:0]   shifted;
		logic [VW+1:0] trial;
		shifted   = {rem_ff[VW-1:0], quo_ff[DW-1]};
		trial     = {1'b0, shifted} - {2'b00, dvs_ff};
		nxt_busy  = busy_ff;
		nxt_cnt   = cnt_ff;
		nxt_rem   = rem_ff;
		nxt_quo   = quo_ff;
		nxt_dvs   = dvs_ff;
		nxt_neg_q = neg_q_ff;
		nxt_neg_r = neg_r_ff;
		nxt_done  = 1'b0;
		nxt_q     = q_ff;
		nxt_r     = r_ff;
		if (start) begin
			nxt_busy  = 1'b1;
			nxt_cnt   = CW'(DW);
			nxt_rem   = '0;
			nxt_quo   = (is_signed && dividend[DW-1]) ? -dividend : dividend;
			nxt_dvs   = (is_signed && divisor[VW-1]) ? -divisor : divisor;
			nxt_neg_q = is_signed & (dividend[DW-1] ^ divisor[VW-1]);
			nxt_neg_r = is_signed & dividend[DW-1];
		end else if (busy_ff) begin
			if (!trial[VW+1]) begin
				nxt_rem = trial[VW:0];
				nxt_quo = {quo_ff[DW-2:0], 1'b1};
			end else begin
				nxt_rem = shifted;
				nxt_quo = {quo_ff[DW-2:0], 1'b0};
			end
			nxt_cnt = cnt_ff - 1'b1;
			if (cnt_ff == CW'(1)) begin
				nxt_busy = 1'b0;
				nxt_done = 1'b1;
				nxt_q    = neg_q_ff ? -nxt_quo[VW-1:0] : nxt_quo[VW-1:0];
				nxt_r    = neg_r_ff ? -nxt_rem[VW-1:0] : nxt_rem[VW-1:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_ff  <= 1'b0;
			cnt_ff   <= '0;
			rem_ff   <= '0;
			quo_ff   <= '0;
			dvs_ff   <= '0;
			neg_q_ff <= 1'b0;
			neg_r_ff <= 1'b0;
			done_ff  <= 1'b0;
			q_ff     <= '0;
			r_ff     <= '0;
		end else begin
			busy_ff  <= nxt_busy;
			cnt_ff   <= nxt_cnt;
			rem_ff   <= nxt_rem;
			quo_ff   <= nxt_quo;
			dvs_ff   <= nxt_dvs;
			neg_q_ff <= nxt_neg_q;
			neg_r_ff <= nxt_neg_r;
			done_ff  <= nxt_done;
			q_ff     <= nxt_q;
			r_ff     <= nxt_r;
		end
	end

	assign done      = done_ff;
	assign quotient  = q_ff;
	assign remainder = r_ff;

endmodule : asmlo_quotient_unit

// ==== test/asmlo_mem_model.sv ====
`timescale 1ns/100ps
module asmlo_mem_model
	import asmlo_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              slow,
	input  wire logic              req,
	input  wire asmlo_mem_type     mem_in,
	output logic                   ack,
	output logic      [WORD_W-1:0] rdata
);
	logic [WORD_W-1:0] mem [256];
	logic [1:0]        wait_cnt;

	// ==========================================================
	// Answer after zero or three cycles; data toggles on every cycle without an answer, waits included
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack      <= 1'b0;
			wait_cnt <= 2'h0;
			rdata    <= 16'h5A5A;
		end else if (req && !ack && wait_cnt == (slow ? 2'h3 : 2'h0)) begin
			ack      <= 1'b1;
			wait_cnt <= 2'h0;
			rdata    <= mem[mem_in.addr[7:0]];
			if (mem_in.we && mem_in.byte_sel)
				mem[mem_in.addr[7:0]][7:0] <= mem_in.wdata[7:0];
			else if (mem_in.we)
				mem[mem_in.addr[7:0]] <= mem_in.wdata;
		end else begin
			ack      <= 1'b0;
			wait_cnt <= (req && !ack) ? wait_cnt + 2'h1 : 2'h0;
			rdata    <= ~rdata;
		end
	end
endmodule : asmlo_mem_model

// ==== test/asmlo_alu_test.sv ====
`timescale 1ns/100ps
module asmlo_alu_test
	import asmlo_pkg::*;
;
	logic                 clk;
	logic                 rst_n;
	logic                 cmd_valid;
	logic                 cmd_ready;
	asmlo_cmd_type        cmd;
	asmlo_load_type       load;
	logic                 mem_req;
	asmlo_mem_type        mem_out;
	logic                 mem_ack;
	logic [WORD_W-1:0]    mem_rdata;
	logic                 done;
	logic [LEN_W-1:0]     insn_len;
	asmlo_flags_type      flags;
	logic [PQ_W-1:0]      pq_reg;
	logic [GPR_IDX_W-1:0] gpr_sel;
	logic [WORD_W-1:0]    gpr_data;
	logic                 slow;
	int                   n_fail = 0;
	int                   n_checks = 0;
	int                   cycles = 0;

	asmlo_alu asmlo_alu_inst (.CLOCK(clk), .RESET_N(rst_n),
		.CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD(cmd),
		.LOAD(load), .MEM_REQ(mem_req), .MEM_OUT(mem_out),
		.MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata), .DONE(done),
		.INSN_LEN(insn_len), .FLAGS(flags), .PQ_REG(pq_reg),
		.GPR_SEL(gpr_sel), .GPR_DATA(gpr_data));

	asmlo_mem_model asmlo_mem_model_inst (.clk(clk), .rst_n(rst_n),
		.slow(slow), .req(mem_req), .mem_in(mem_out), .ack(mem_ack),
		.rdata(mem_rdata));

	// ==========================================================
	// Report and compare
	task automatic test_done;
		if (n_fail == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic gpr_is(input logic [3:0] s, input logic [15:0] e);
		@(negedge clk);
		gpr_sel = s;
		@(negedge clk);
		cmp(32'(gpr_data), 32'(e));
	endtask : gpr_is

	task automatic mem_is(input logic [7:0] a, input logic [15:0] e);
		cmp(32'(asmlo_mem_model_inst.mem[a]), 32'(e));
	endtask : mem_is

	// ==========================================================
	// Drivers
	task automatic set_gpr(input logic [3:0] s, input logic [15:0] d);
		@(negedge clk);
		load = '{gpr_en: 1'b1, sel: s, data: d, default: '0};
		@(negedge clk);
		load = '0;
	endtask : set_gpr

	task automatic set_misc(input logic [31:0] pq, input logic c);
		@(negedge clk);
		load = '{pq_en: 1'b1, pq: pq, flags_en: 1'b1,
			flags: '{c, 1'b0, 1'b0, 1'b0}, default: '0};
		@(negedge clk);
		load = '0;
	endtask : set_misc

	task automatic run(input asmlo_op_type o, input asmlo_form_type f,
		input logic b, input logic [3:0] d, input logic [3:0] s,
		input logic [15:0] i, input logic [15:0] a);
		int n;
		@(negedge clk);
		cmd = '{o, f, b, d, s, i, a};
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		cmp(32'(cmd_ready), 32'h0000_0000);
		n = 0;
		while (done !== 1'b1 && n < 60) begin
			@(negedge clk);
			n++;
		end
		cmp(32'(done), 32'h0000_0001);
		cmp(32'(cmd_ready), 32'h0000_0001);
	endtask : run

	// ==========================================================
	// Scenarios
	task automatic t_minus;
		set_gpr(4'h1, 16'h0005);
		set_gpr(4'h2, 16'h0007);
		run(OP_MINUS, FORM_REG_REG, 1'b0, 4'h1, 4'h2, 16'h0000, 16'h0000);
		cmp(32'(insn_len), 32'h0000_0002);
		cmp(32'(flags), 32'h0000_0009);
		gpr_is(4'h1, 16'hFFFE);
		run(OP_BITWISE_EXCLUSIVE, FORM_REG_REG, 1'b0, 4'h1, 4'h1, 16'h0000,
			16'h0000);
		cmp(32'(flags), 32'h0000_0002);
		gpr_is(4'h1, 16'h0000);
	endtask : t_minus

	task automatic t_borrow;
		set_gpr(4'h3, 16'h550A);
		set_misc(32'h0000_0000, 1'b1);
		run(OP_MINUS_BORROW, FORM_IMM3, 1'b0, 4'h3, 4'h3, 16'h0003, 16'h0000);
		gpr_is(4'h3, 16'h5506);
		set_misc(32'h0000_0000, 1'b1);
		run(OP_MINUS_BORROW, FORM_IMM_LONG, 1'b1, 4'h6, 4'h6, 16'h0001,
			16'h0000);
		cmp(32'(insn_len), 32'h0000_0004);
		gpr_is(4'h3, 16'h5504);
	endtask : t_borrow

	task automatic t_fetch;
		set_gpr(4'h4, 16'h0010);
		set_gpr(4'h5, 16'h0009);
		slow = 1'b1;
		run(OP_MINUS, FORM_IND_INC, 1'b0, 4'h5, 4'h4, 16'h0000, 16'h0000);
		slow = 1'b0;
		cmp(32'(insn_len), 32'h0000_0002);
		gpr_is(4'h5, 16'h0006);
		gpr_is(4'h4, 16'h0012);
		set_gpr(4'h6, 16'h0020);
		set_gpr(4'h7, 16'h12FF);
		run(OP_BITWISE_CONJ, FORM_IND_INC, 1'b1, 4'hE, 4'h6, 16'h0000,
			16'h0000);
		gpr_is(4'h7, 16'h12F0);
		gpr_is(4'h6, 16'h0021);
	endtask : t_fetch

	task automatic t_memory;
		set_gpr(4'h8, 16'h0F0F);
		set_gpr(4'h9, 16'h00C0);
		run(OP_BITWISE_EXCLUSIVE, FORM_MEM_REG, 1'b0, 4'h8, 4'h8, 16'h0000,
			16'h0030);
		cmp(32'(insn_len), 32'h0000_0004);
		mem_is(8'h30, 16'h1D3B);
		run(OP_BITWISE_DISJ, FORM_REG_MEM, 1'b0, 4'h9, 4'h9, 16'h0000,
			16'h0030);
		gpr_is(4'h9, 16'h1DFB);
		set_gpr(4'hA, 16'hFF00);
		run(OP_BITWISE_CONJ, FORM_IMM_LONG, 1'b0, 4'hA, 4'hA, 16'h0FF0,
			16'h0000);
		gpr_is(4'hA, 16'h0F00);
	endtask : t_memory

	task automatic t_muldiv;
		asmlo_op_type o [4] = '{OP_SIGNED_QUOTIENT_SHORT,
			OP_UNSIGNED_QUOTIENT_SHORT, OP_SIGNED_QUOTIENT_LONG,
			OP_UNSIGNED_QUOTIENT_LONG};
		logic [31:0] p [4] = '{32'h0000_FF9C, 32'h1234_FF9C, 32'hFFFE_0000,
			32'h0001_0000};
		logic [31:0] e [4] = '{32'hFFFE_FFF2, 32'h0000_2484, 32'hFFFC_B6DC,
			32'h0002_2492};
		set_gpr(4'h1, 16'hFFFE);
		set_gpr(4'h2, 16'h0003);
		run(OP_SIGNED_PRODUCT, FORM_REG_REG, 1'b0, 4'h1, 4'h2, 16'h0000,
			16'h0000);
		cmp(pq_reg, 32'hFFFF_FFFA);
		run(OP_UNSIGNED_PRODUCT, FORM_REG_REG, 1'b0, 4'h1, 4'h2, 16'h0000,
			16'h0000);
		cmp(pq_reg, 32'h0002_FFFA);
		set_gpr(4'h2, 16'h0007);
		for (int k = 0; k < 4; k++) begin
			set_misc(p[k], 1'b0);
			run(o[k], FORM_REG_REG, 1'b0, 4'h2, 4'h2, 16'h0000, 16'h0000);
			cmp(pq_reg, e[k]);
		end
	endtask : t_muldiv

	task automatic t_unary;
		set_gpr(4'hB, 16'h00F0);
		set_gpr(4'h3, 16'h5504);
		run(OP_INVERT, FORM_REG_REG, 1'b0, 4'hB, 4'hB, 16'h0000, 16'h0000);
		gpr_is(4'hB, 16'hFF0F);
		run(OP_TWOS_COMPLEMENT, FORM_REG_REG, 1'b0, 4'hB, 4'hB, 16'h0000,
			16'h0000);
		gpr_is(4'hB, 16'h00F1);
		run(OP_INVERT, FORM_REG_REG, 1'b1, 4'h7, 4'h7, 16'h0000, 16'h0000);
		gpr_is(4'h3, 16'hAA04);
		run(OP_TWOS_COMPLEMENT, FORM_REG_REG, 1'b1, 4'h7, 4'h7, 16'h0000,
			16'h0000);
		gpr_is(4'h3, 16'h5604);
	endtask : t_unary

	// ==========================================================
	// Clock, watchdog, main sequence
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			test_done();
		end
	end

	initial begin
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd = '0;
		load = '0;
		gpr_sel = '0;
		slow = 1'b0;
		asmlo_mem_model_inst.mem[8'h10] = 16'h0003;
		asmlo_mem_model_inst.mem[8'h20] = 16'hABF0;
		asmlo_mem_model_inst.mem[8'h30] = 16'h1234;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		t_minus();
		t_borrow();
		t_fetch();
		t_memory();
		t_muldiv();
		t_unary();
		test_done();
	end
endmodule : asmlo_alu_test
